// *** shared/pack_protect_pkg.sv ***
package pack_protect_pkg;

  // timebase
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CNT_W = 24;

  // persistence and sampling times, in their printed units
  localparam int unsigned DISCH_QUAL_MS = 3;
  localparam int unsigned CHARGE_QUAL_MS = 3;
  localparam int unsigned SHORT_QUAL_US = 450;
  localparam int unsigned STANDBY_MS = 79;
  localparam int unsigned SAMPLE_TENTH_MS = 5;

  // cycle counts derived from the times
  localparam int unsigned DISCH_QUAL_CYC = DISCH_QUAL_MS * 1000 * CLK_MHZ;
  localparam int unsigned CHARGE_QUAL_CYC = CHARGE_QUAL_MS * 1000 * CLK_MHZ;
  localparam int unsigned SHORT_QUAL_CYC = SHORT_QUAL_US * CLK_MHZ;
  localparam int unsigned STANDBY_CYC = STANDBY_MS * 1000 * CLK_MHZ;
  localparam int unsigned SAMPLE_CYC = SAMPLE_TENTH_MS * 100 * CLK_MHZ;

  // consecutive samples needed to flag a cell fault
  localparam logic [2:0] CELL_SAMPLES = 3'h4;
  localparam int unsigned CELLS = 4;

  // register map
  localparam logic [3:0] FAULT_STATUS_ADDR = 4'h0;
  localparam logic [3:0] EVENT_STATUS_ADDR = 4'h4;
  localparam logic [3:0] EVENT_CLEAR_ADDR = 4'h8;
  localparam logic [3:0] EVENT_ENABLE_ADDR = 4'hC;
  localparam logic [7:0] EVENT_ENABLE_RST = 8'h00;

  // event bit positions, shared by status, clear and enable
  localparam int unsigned EV_DISCH = 0;
  localparam int unsigned EV_SHORT = 1;
  localparam int unsigned EV_CHARGE = 2;
  localparam int unsigned EV_OVER = 3;
  localparam int unsigned EV_UNDER = 4;
  localparam int unsigned EV_W = 5;

  typedef enum logic [1:0] {
    SHUTDOWN,
    STANDBY,
    SAMPLE
  } mode_t;

  typedef struct packed {
    logic             dischargeCmp;
    logic             shortCmp;
    logic             chargeCmp;
    logic             chargerCmp;
    logic [CELLS-1:0] cellHigh;
    logic [CELLS-1:0] cellLow;
  } sense_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic trickle;
    logic fast;
    logic discharge;
  } gates_t;

endpackage

// *** rtl/persist_timer.sv ***
`timescale 1ns/100ps
module persist_timer #(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cmpIn,
  output logic      qualified
);
  import pack_protect_pkg::*;

  localparam logic [CNT_W-1:0] LIMIT_C = CNT_W'(LIMIT);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wire              atLimit = (cnt_q == LIMIT_C);

  // restart on any drop before the limit
  assign cnt_d = !cmpIn ? '0 : (atLimit ? cnt_q : cnt_q + 1'b1);
  assign qualified = cmpIn && atLimit;

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_timer_restart: assert property (!cmpIn |=> cnt_q == '0)
    else $error("persistence count not restarted");
  a_timer_qualify: assert property (qualified |-> $past(cnt_q) == LIMIT_C
    || $past(cnt_q) == LIMIT_C - 1'b1)
    else $error("qualified before persistence time");

endmodule

// *** rtl/pack_protect_fault_fsm.sv ***
`timescale 1ns/100ps
module pack_protect_fault_fsm #(
  parameter int unsigned DISCH_CYC   = pack_protect_pkg::DISCH_QUAL_CYC,
  parameter int unsigned CHARGE_CYC  = pack_protect_pkg::CHARGE_QUAL_CYC,
  parameter int unsigned SHORT_CYC   = pack_protect_pkg::SHORT_QUAL_CYC,
  parameter int unsigned STANDBY_LEN = pack_protect_pkg::STANDBY_CYC,
  parameter int unsigned SAMPLE_LEN  = pack_protect_pkg::SAMPLE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire pack_protect_pkg::sense_t   sense,
  input  wire logic                       switch_override_in,
  input  wire logic                       sleep_request_in,
  input  wire pack_protect_pkg::bus_req_t bus,
  output logic [7:0]                      rdata,
  output logic                            irq,
  output logic                            discharge_gate_n,
  output logic                            fastcharge_gate_n,
  output logic                            trickle_gate_n,
  output logic                            sleepMode
);
  import pack_protect_pkg::*;

  localparam logic [CNT_W-1:0] STANDBY_END = CNT_W'(STANDBY_LEN - 1);
  localparam logic [CNT_W-1:0] SAMPLE_END  = CNT_W'(SAMPLE_LEN - 1);

  mode_t            mode_q;
  mode_t            mode_d;
  logic [CNT_W-1:0] phase_q;
  logic [CNT_W-1:0] phase_d;
  logic             charger_q;
  logic [2:0]       ovCnt_q;
  logic [2:0]       ovCnt_d;
  logic [2:0]       uvCnt_q;
  logic [2:0]       uvCnt_d;
  logic             ovFlag_q;
  logic             ovFlag_d;
  logic             lowSeen_q;
  logic             lowSeen_d;
  logic             dischFault_q;
  logic             shortFault_q;
  logic             chargeFault_q;
  logic [EV_W-1:0]  evStat_q;
  logic [EV_W-1:0]  evEn_q;
  gates_t           gates_q;
  gates_t           gatesOff;
  logic [2:0]       qual;
  logic [2:0]       cmpRun;

  // charger detect comparator, sampled every cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      charger_q <= 1'b0;
    else
      charger_q <= sense.chargerCmp;
  end

  // sampling phase timing
  wire active     = (mode_q != SHUTDOWN);
  wire standbyEnd = (mode_q == STANDBY) && (phase_q == STANDBY_END);
  wire sampleEnd  = (mode_q == SAMPLE) && (phase_q == SAMPLE_END);
  wire anyHigh    = |sense.cellHigh;
  wire anyLow     = |sense.cellLow;
  // the count saturates while charging, so a run already past four trips
  wire uvTrip     = sampleEnd && anyLow && (uvCnt_q >= CELL_SAMPLES - 3'h1);
  wire uvShutdown = uvTrip && !charger_q;
  wire ovTrip     = sampleEnd && anyHigh && (ovCnt_q == CELL_SAMPLES - 3'h1);

  assign phase_d = (standbyEnd || sampleEnd || !active) ? '0
                 : phase_q + 1'b1;

  // mode machine; override and sleep inputs never enter here
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      SHUTDOWN:
        if (charger_q)
          mode_d = STANDBY;
      STANDBY:
        if (standbyEnd)
          mode_d = SAMPLE;
      SAMPLE:
        if (uvShutdown)
          mode_d = SHUTDOWN;
        else if (sampleEnd)
          mode_d = STANDBY;
      default:
        mode_d = STANDBY;
    endcase
  end

  // consecutive sample counters and cell flags
  assign ovCnt_d = !sampleEnd ? ovCnt_q
                 : !anyHigh ? 3'h0
                 : (ovCnt_q == CELL_SAMPLES) ? ovCnt_q
                 : ovCnt_q + 3'h1;
  assign uvCnt_d = !active ? 3'h0
                 : !sampleEnd ? uvCnt_q
                 : !anyLow ? 3'h0
                 : (uvCnt_q == CELL_SAMPLES) ? uvCnt_q
                 : uvCnt_q + 3'h1;
  assign ovFlag_d = ovTrip ? 1'b1
                  : (sampleEnd && !anyHigh) ? 1'b0
                  : ovFlag_q;
  assign lowSeen_d = (sampleEnd && anyLow) ? 1'b1
                   : (sampleEnd && !anyLow) ? 1'b0
                   : lowSeen_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q    <= STANDBY;
      phase_q   <= '0;
      ovCnt_q   <= 3'h0;
      uvCnt_q   <= 3'h0;
      ovFlag_q  <= 1'b0;
      lowSeen_q <= 1'b0;
    end
    else
    begin
      mode_q    <= mode_d;
      phase_q   <= phase_d;
      ovCnt_q   <= ovCnt_d;
      uvCnt_q   <= uvCnt_d;
      ovFlag_q  <= ovFlag_d;
      lowSeen_q <= lowSeen_d;
    end
  end

  // current comparators watched in STANDBY and SAMPLE, sleep included, masked only in SHUTDOWN
  assign cmpRun = {sense.chargeCmp, sense.shortCmp, sense.dischargeCmp}
                & {3{active}};

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_qual
      persist_timer #(
        .LIMIT ((i == 0) ? DISCH_CYC : (i == 1) ? SHORT_CYC : CHARGE_CYC)
      ) u_timer (
        .clk       (clk),
        .rst       (rst),
        .cmpIn     (cmpRun[i]),
        .qualified (qual[i])
      );
    end
  endgenerate

  // latched current faults; a new trip wins over the reversal clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dischFault_q  <= 1'b0;
      shortFault_q  <= 1'b0;
      chargeFault_q <= 1'b0;
    end
    else
    begin
      dischFault_q  <= qual[0] | (dischFault_q & !charger_q);
      shortFault_q  <= qual[1] | (shortFault_q & !charger_q);
      chargeFault_q <= qual[2] | (chargeFault_q & charger_q);
    end
  end

  // gate off requests from every source
  wire forceOff  = switch_override_in | sleep_request_in;
  wire sleepNow  = sleep_request_in & !charger_q;
  wire faultAll  = dischFault_q | shortFault_q;
  wire chargeOff = ovFlag_q | chargeFault_q;
  wire downOff   = (mode_q == SHUTDOWN);

  assign gatesOff.discharge = faultAll | forceOff | downOff | lowSeen_q
                            | chargeFault_q;
  assign gatesOff.fast = faultAll | forceOff | downOff | lowSeen_q
                       | chargeOff;
  // trickle stays on through a low cell while charging
  assign gatesOff.trickle = faultAll | forceOff | downOff
                          | chargeOff | (lowSeen_q & !charger_q);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gates_q   <= '{trickle: 1'b1, fast: 1'b1, discharge: 1'b1};
      sleepMode <= 1'b0;
    end
    else
    begin
      gates_q   <= gatesOff;
      sleepMode <= sleepNow | downOff;
    end
  end

  assign discharge_gate_n  = gates_q.discharge;
  assign fastcharge_gate_n = gates_q.fast;
  assign trickle_gate_n    = gates_q.trickle;

  // event capture, enable and clear registers
  wire [EV_W-1:0] evSet = {uvShutdown, ovTrip, qual[2], qual[1], qual[0]};
  wire            wrClr = bus.wr && (bus.addr == EVENT_CLEAR_ADDR);
  wire            wrEn  = bus.wr && (bus.addr == EVENT_ENABLE_ADDR);
  wire [EV_W-1:0] clrMask = wrClr ? bus.wdata[EV_W-1:0] : '0;
  wire [EV_W-1:0] evStat_d = evSet | (evStat_q & ~clrMask);
  wire [7:0] faultView = {1'b0, sleepMode, mode_q == SHUTDOWN, charger_q,
                          ovFlag_q, chargeFault_q, shortFault_q,
                          dischFault_q};
  wire [7:0] rdSel;

  assign rdSel = (bus.addr == FAULT_STATUS_ADDR) ? faultView
               : (bus.addr == EVENT_STATUS_ADDR) ? {3'h0, evStat_q}
               : (bus.addr == EVENT_ENABLE_ADDR) ? {3'h0, evEn_q}
               : 8'h00;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      evStat_q <= '0;
      evEn_q   <= EVENT_ENABLE_RST[EV_W-1:0];
      rdata    <= 8'h00;
      irq      <= 1'b0;
    end
    else
    begin
      evStat_q <= evStat_d;
      if (wrEn)
        evEn_q <= bus.wdata[EV_W-1:0];
      rdata <= bus.rd ? rdSel : 8'h00;
      irq   <= |(evStat_d & evEn_q);
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_override_held;
    switch_override_in ##1 switch_override_in;
  endsequence

  a_override_gates: assert property (s_override_held |-> discharge_gate_n
    && fastcharge_gate_n && trickle_gate_n)
    else $error("override did not switch all gates off");
  a_sleep_gates: assert property (sleep_request_in |=> discharge_gate_n
    && fastcharge_gate_n && trickle_gate_n
    && (sleepMode || $past(charger_q)))
    else $error("sleep request did not switch gates off");
  a_disch_latch: assert property (dischFault_q && !charger_q
    |=> dischFault_q)
    else $error("discharge fault cleared without charger");
  a_short_latch: assert property (shortFault_q && !charger_q
    |=> shortFault_q ##1 discharge_gate_n)
    else $error("short fault cleared without charger");
  a_disch_trip: assert property (qual[0] |=> dischFault_q ##1
    (discharge_gate_n && fastcharge_gate_n && trickle_gate_n))
    else $error("discharge trip did not turn gates off");
  a_short_trip: assert property (qual[1] |=> ##1 (discharge_gate_n
    && fastcharge_gate_n && trickle_gate_n))
    else $error("short trip did not turn gates off");
  a_ov_four: assert property ($rose(ovFlag_q) |-> $past(ovCnt_q)
    == CELL_SAMPLES - 3'h1 && ovCnt_q == CELL_SAMPLES)
    else $error("overvoltage flagged before four samples");
  a_uv_shutdown: assert property (uvShutdown |=> mode_q == SHUTDOWN
    ##1 (discharge_gate_n && fastcharge_gate_n))
    else $error("undervoltage did not shut down");
  a_trickle_low: assert property (lowSeen_q && charger_q && !forceOff
    && !faultAll && !chargeOff && active |=> !trickle_gate_n
    && fastcharge_gate_n)
    else $error("trickle not enabled for low cell");
  a_mode_keep: assert property ($changed(switch_override_in)
    && !uvShutdown && !standbyEnd && !sampleEnd && !(mode_q == SHUTDOWN)
    |=> mode_q == $past(mode_q))
    else $error("override changed the mode");
  a_standby_len: assert property (mode_q == STANDBY
    |-> phase_q <= STANDBY_END)
    else $error("standby ran past its length");

endmodule

// *** sim/pack_switch_model.sv ***
`timescale 1ns/100ps
module pack_switch_model (
  input  wire pack_protect_pkg::gates_t gateN,
  output pack_protect_pkg::gates_t      switchOn
);
  import pack_protect_pkg::*;
  // p-channel switch conducts only while its gate is pulled low
  assign switchOn = ~gateN;
endmodule

// *** sim/pack_protect_fault_fsm_test.sv ***
`timescale 1ns/100ps
module pack_protect_fault_fsm_test;
  import pack_protect_pkg::*;
  localparam int unsigned QD = 20;
  localparam int unsigned QS = 12;
  logic       clk;
  logic       rst;
  sense_t     sense;
  logic       switchOverride;
  logic       sleepRequest;
  bus_req_t   bus;
  logic [7:0] rdata;
  logic       irq;
  logic       dischN;
  logic       fastN;
  logic       trickleN;
  logic       sleepMode;
  gates_t     gateN;
  gates_t     switchOn;
  logic [2:0] gv;
  int         err_count;
  int         compares;
  assign gateN = {trickleN, fastN, dischN};
  assign gv = ~switchOn;
  pack_protect_fault_fsm #(
    .DISCH_CYC  (QD),
    .CHARGE_CYC (QD),
    .SHORT_CYC  (QS),
    .STANDBY_LEN(50),
    .SAMPLE_LEN (10)
  ) u_pack_protect_fault_fsm (
    .clk               (clk),
    .rst               (rst),
    .sense             (sense),
    .switch_override_in(switchOverride),
    .sleep_request_in  (sleepRequest),
    .bus               (bus),
    .rdata             (rdata),
    .irq               (irq),
    .discharge_gate_n  (dischN),
    .fastcharge_gate_n (fastN),
    .trickle_gate_n    (trickleN),
    .sleepMode         (sleepMode)
  );
  pack_switch_model u_pack_switch_model (
    .gateN   (gateN),
    .switchOn(switchOn)
  );
  always #5 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // all tasks start and end on a rising edge
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
    check(rdata, e);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
    // let an edge pass so the strobe drops before a following write raises it again
    @(posedge clk);
  endtask
  task automatic waitGates(input logic [2:0] m, input logic [2:0] e,
                           input int n);
    int k;
    k = 0;
    while (((gv & m) !== e) && k < n)
    begin
      @(posedge clk);
      k++;
    end
    check({5'h0, gv & m}, {5'h0, e});
  endtask
  task automatic setCmp(input int i, input logic v);
    if (i == 0)
      sense.dischargeCmp <= v;
    else
      sense.shortCmp <= v;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  initial
  begin
    #200000;
    err_count++;
    test_done();
  end
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    sense = '0;
    bus = '0;
    switchOverride = 1'b0;
    sleepRequest = 1'b0;
    err_count = 0;
    compares = 0;
    cyc(12);
    check({5'h0, gv}, 8'h07);
    rst <= 1'b0;
    @(posedge clk);
    waitGates(3'h7, 3'h0, 4);
    rd(4'hC, 8'h00);
    wr(4'hC, 8'h1F);
    rd(4'hC, 8'h1F);
    wr(4'hC, 8'h00);
    wr(4'h2, 8'hFF);
    rd(4'h2, 8'h00);
    rd(4'h8, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      setCmp(i, 1'b1);
      cyc(i == 0 ? QD : QS);
      setCmp(i, 1'b0);
      cyc(6);
      check({5'h0, gv}, 8'h00);
      setCmp(i, 1'b1);
      waitGates(3'h7, 3'h7, QD + 6);
      setCmp(i, 1'b0);
      switchOverride <= 1'b1;
      sleepRequest <= 1'b1;
      cyc(4);
      switchOverride <= 1'b0;
      sleepRequest <= 1'b0;
      cyc(6);
      rd(4'h0, 8'h01 << i);
      check({5'h0, gv}, 8'h07);
      rd(4'h4, 8'h01 << i);
      wr(4'hC, 8'h01 << i);
      cyc(3);
      check({7'h0, irq}, 8'h01);
      wr(4'h8, 8'h01 << i);
      cyc(3);
      check({7'h0, irq}, 8'h00);
      rd(4'h4, 8'h00);
      sense.chargerCmp <= 1'b1;
      cyc(4);
      rd(4'h0, 8'h10);
      sense.chargerCmp <= 1'b0;
      waitGates(3'h7, 3'h0, 6);
    end
    sense.chargerCmp <= 1'b1;
    sense.chargeCmp <= 1'b1;
    waitGates(3'h6, 3'h6, QD + 6);
    sense.chargeCmp <= 1'b0;
    cyc(6);
    check({5'h0, gv & 3'h6}, 8'h06);
    sense.chargerCmp <= 1'b0;
    waitGates(3'h7, 3'h0, 6);
    switchOverride <= 1'b1;
    waitGates(3'h7, 3'h7, 3);
    switchOverride <= 1'b0;
    waitGates(3'h7, 3'h0, 3);
    sleepRequest <= 1'b1;
    cyc(3);
    check({7'h0, sleepMode}, 8'h01);
    check({5'h0, gv}, 8'h07);
    sleepRequest <= 1'b0;
    waitGates(3'h7, 3'h0, 3);
    sense.cellHigh <= 4'h2;
    cyc(100);
    check({5'h0, gv}, 8'h00);
    waitGates(3'h6, 3'h6, 260);
    check({7'h0, gv[0]}, 8'h00);
    sense.cellHigh <= 4'h0;
    waitGates(3'h7, 3'h0, 70);
    sense.chargerCmp <= 1'b1;
    sense.cellLow <= 4'h1;
    waitGates(3'h7, 3'h3, 70);
    cyc(130);
    check({5'h0, gv}, 8'h03);
    sense.chargerCmp <= 1'b0;
    cyc(300);
    rd(4'h0, 8'h60);
    check({5'h0, gv}, 8'h07);
    sense.cellLow <= 4'h0;
    sense.chargerCmp <= 1'b1;
    cyc(5);
    rd(4'h0, 8'h10);
    sense.chargerCmp <= 1'b0;
    waitGates(3'h7, 3'h0, 70);
    test_done();
  end
endmodule
